// [giv_iv_builder.sv]
// Deterministic GCM vector construction with ordering stall and self-test gate
//
// Overview of operation
// RL1: The known-answer self-tests start by themselves after reset with no setup.
// RL2: No crypto service is given until all self-tests pass; any failure is an error state.
// RL3: In the error state nothing is encrypted or forwarded and control requests come back unprocessed.
// RL4: Every vector is 96 bits built here from a 32-bit fixed part and a 64-bit variable part.
// RL5: Table entry vectors join the table salt with the sampled 64-bit table add counter.
// RL6: Output is held until the new variable part is strictly above the previous one.
// RL7: The table add counter has no wrap detection and is assumed never to wrap.
// RL8: ESP vectors join the association salt with its 64-bit packet sequence number.
// RL9: An ESP sequence number at its wrap point deactivates that association.
// RL10: PSP vectors join the association salt with the 64-bit free-running master timer.
// RL11: The master timer wraps freely and a PSP association older than two days is retired.
// RL12: The fixed part sits in the upper 32 bits and the variable part in the lower 64.
`timescale 1ns/1ps
module giv_iv_builder
  import giv_pkg::*;
#(
  parameter logic [63:0] PSP_LIFE_CYC = GIV_PSP_LIFE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  output logic katStart,
  output logic [2:0] katSel,
  input wire logic katDone,
  input wire logic katPass,
  output logic cryptoReady,
  output logic selftestError,
  input wire logic ctrlReq,
  output logic ctrlAccept,
  output logic ctrlReject,
  input wire logic [giv_pkg::GIV_FIX_W-1:0] tableSalt,
  input wire logic tableAdd,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [giv_pkg::GIV_SCH_W-1:0] reqScheme,
  input wire logic [giv_pkg::GIV_SA_W-1:0] reqSaIndex,
  input wire logic [giv_pkg::GIV_FIX_W-1:0] reqSalt,
  input wire logic [giv_pkg::GIV_VAR_W-1:0] reqSeqNum,
  input wire logic [giv_pkg::GIV_VAR_W-1:0] reqSaStart,
  output logic outStall,
  output logic saDeact,
  output logic [giv_pkg::GIV_SA_W-1:0] saDeactIndex,
  output logic [giv_pkg::GIV_VAR_W-1:0] masterTime,
  output logic ivValid,
  input wire logic ivReady,
  output logic [giv_pkg::GIV_SCH_W-1:0] ivScheme,
  output logic [giv_pkg::GIV_SA_W-1:0] ivSaIndex,
  output logic [giv_pkg::GIV_IV_W-1:0] ivData
);
  import giv_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [GIV_VAR_W-1:0] addCount_r;
  logic [GIV_VAR_W-1:0] timer_r;
  logic [GIV_VAR_W-1:0] lastVar_r [GIV_NUM_SCH];
  logic saDeact_r;
  logic [GIV_SA_W-1:0] saDeactIndex_r;
  logic fifoInReady;
  logic fifoOutValid;
  logic [GIV_DESC_W-1:0] fifoOutData;

  // ----------------------------------------
  // Self-test gate
  // ----------------------------------------
  giv_selftest u_selftest (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .katStart(katStart),
    .katSel(katSel),
    .katDone(katDone),
    .katPass(katPass),
    .cryptoReady(cryptoReady),
    .selftestError(selftestError)
  );

  // RL3: control bounced while in error
  assign ctrlAccept = ctrlReq & cryptoReady;
  assign ctrlReject = ctrlReq & selftestError;

  // ----------------------------------------
  // Counter sources
  // ----------------------------------------
  // RL7: no wrap check on add counter
  always_ff @(posedge sys_clk) begin
    if (!resetn) addCount_r <= GIV_VAR_RST;
    else if (tableAdd) addCount_r <= addCount_r + 64'h1;
  end

  // RL11: master timer wraps freely
  always_ff @(posedge sys_clk) begin
    if (!resetn) timer_r <= GIV_VAR_RST;
    else timer_r <= timer_r + 64'h1;
  end
  assign masterTime = timer_r;

  // ----------------------------------------
  // Scheme decode
  // ----------------------------------------
  wire isTable = (reqScheme == GIV_SCH_TABLE);
  wire isEsp = (reqScheme == GIV_SCH_ESP);
  wire isPsp = (reqScheme == GIV_SCH_PSP);
  wire isKnown = isTable | isEsp | isPsp;

  // RL5: table salt with add counter
  wire [GIV_FIX_W-1:0] tableFix = tableSalt;
  wire [GIV_VAR_W-1:0] tableVar = addCount_r;
  // RL8: association salt with sequence
  wire [GIV_FIX_W-1:0] espFix = reqSalt;
  wire [GIV_VAR_W-1:0] espVar = reqSeqNum;
  // RL10: association salt with master timer
  wire [GIV_FIX_W-1:0] pspFix = reqSalt;
  wire [GIV_VAR_W-1:0] pspVar = timer_r;

  wire [GIV_FIX_W-1:0] candFix = isTable ? tableFix : (isEsp ? espFix : pspFix);
  wire [GIV_VAR_W-1:0] candVar = isTable ? tableVar : (isEsp ? espVar : pspVar);
  wire [1:0] schIdx = isKnown ? reqScheme : GIV_SCH_TABLE;
  wire [GIV_VAR_W-1:0] prevVar = lastVar_r[schIdx];

  // RL4: 96-bit vector from two fields
  // RL12: fixed part on top
  wire [GIV_IV_W-1:0] candIv = {candFix, candVar};

  // ----------------------------------------
  // Lifetime and wrap checks
  // ----------------------------------------
  // RL9: sequence at wrap point
  wire espWrap = isEsp & (reqSeqNum == GIV_SEQ_MAX);
  wire [GIV_VAR_W-1:0] pspAge = timer_r - reqSaStart;
  // RL11: two-day association limit
  wire pspExpired = isPsp & (pspAge > PSP_LIFE_CYC);
  wire needDeact = espWrap | pspExpired;

  // ----------------------------------------
  // Request acceptance
  // ----------------------------------------
  // Strict compare keeps a repeated value from ever leaving
  wire isGreater = (candVar > prevVar);
  // RL2: requests wait for self-test pass
  wire canRun = reqValid & cryptoReady;
  wire doDeact = canRun & isKnown & needDeact;
  wire doDrop = canRun & ~isKnown;
  // RL6: emit only on strictly larger value
  wire doEmit = canRun & isKnown & ~needDeact & isGreater & fifoInReady;

  assign reqReady = doDeact | doDrop | doEmit;
  // RL6: stall while ordering or space blocks
  assign outStall = canRun & isKnown & ~needDeact & ~(isGreater & fifoInReady);

  // ----------------------------------------
  // Previous value per scheme
  // ----------------------------------------
  // Tracked per scheme, not per association: stricter, and needs no table
  genvar gi;
  generate
    for (gi = 0; gi < GIV_NUM_SCH; gi++) begin : gLast
      wire hit = doEmit & (schIdx == 2'(gi));
      // RL6: remember last issued value
      always_ff @(posedge sys_clk) begin
        if (!resetn) lastVar_r[gi] <= GIV_VAR_RST;
        else if (hit) lastVar_r[gi] <= candVar;
      end
    end
  endgenerate

  // ----------------------------------------
  // Deactivation notice
  // ----------------------------------------
  // RL9, RL11: retire wrapped or expired association
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      saDeact_r <= 1'b0;
      saDeactIndex_r <= '0;
    end else begin
      saDeact_r <= doDeact;
      if (doDeact) saDeactIndex_r <= reqSaIndex;
    end
  end
  assign saDeact = saDeact_r;
  assign saDeactIndex = saDeactIndex_r;

  // ----------------------------------------
  // Output buffer
  // ----------------------------------------
  wire [GIV_DESC_W-1:0] fifoInData = {reqScheme, reqSaIndex, candIv};
  // RL3: nothing leaves unless service is up
  wire fifoOutReady = ivReady & cryptoReady;

  giv_fifo #(
    .WIDTH(GIV_DESC_W),
    .DEPTH(GIV_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .inValid(doEmit),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // RL3: output frozen in error
  assign ivValid = fifoOutValid & cryptoReady;
  assign ivScheme = fifoOutData[GIV_DESC_W-1 -: GIV_SCH_W];
  assign ivSaIndex = fifoOutData[GIV_IV_W +: GIV_SA_W];
  assign ivData = fifoOutData[GIV_IV_W-1:0];
endmodule

// [giv_pkg.sv]
// Shared constants and types for the GCM vector construction block
package giv_pkg;
  // ----------------------------------------
  // Vector layout
  // ----------------------------------------
  localparam int GIV_FIX_W = 32;
  localparam int GIV_VAR_W = 64;
  localparam int GIV_IV_W = 96;
  localparam int GIV_FIX_LSB = 64;
  localparam int GIV_SA_W = 16;
  localparam int GIV_SCH_W = 2;
  localparam int GIV_DESC_W = GIV_SCH_W + GIV_SA_W + GIV_IV_W;
  localparam int GIV_NUM_SCH = 3;
  // ----------------------------------------
  // Schemes
  // ----------------------------------------
  localparam logic [1:0] GIV_SCH_TABLE = 2'h0;
  localparam logic [1:0] GIV_SCH_ESP = 2'h1;
  localparam logic [1:0] GIV_SCH_PSP = 2'h2;
  // ----------------------------------------
  // Reset values and sequence wrap point
  // ----------------------------------------
  localparam logic [63:0] GIV_VAR_RST = 64'h0;
  localparam logic [63:0] GIV_SEQ_MAX = 64'hffff_ffff_ffff_ffff;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint GIV_CLK_HZ = 50_000_000;
  localparam longint GIV_PSP_LIFE_S = 172_800;
  localparam logic [63:0] GIV_PSP_LIFE_CYC = 64'(GIV_PSP_LIFE_S * GIV_CLK_HZ);
  localparam logic [11:0] GIV_KAT_TIMEOUT_CYC = 12'hfff;
  // ----------------------------------------
  // Self-test and output buffer
  // ----------------------------------------
  localparam int GIV_NUM_KAT = 5;
  localparam logic [2:0] GIV_KAT_LAST = 3'h4;
  localparam int GIV_FIFO_DEPTH = 32;
  typedef enum logic [3:0] {
    GIV_ST_START = 4'b0001,
    GIV_ST_RUN = 4'b0010,
    GIV_ST_PASS = 4'b0100,
    GIV_ST_FAIL = 4'b1000
  } giv_st_e;
endpackage

// [giv_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module giv_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;
  // ----------------------------------------
  // Status
  // ----------------------------------------
  assign inReady = (count_r != (AW + 1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  // Pointers wrap naturally: depth is a power of two
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= rdPtr_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end
  // No reset on storage: contents are qualified by count
  always_ff @(posedge sys_clk) begin
    if (push) mem[wrPtr_r] <= inData;
  end
endmodule

// [giv_selftest.sv]
// Power-on known-answer test sequencer gating crypto service
`timescale 1ns/1ps
module giv_selftest
  import giv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  output logic katStart,
  output logic [2:0] katSel,
  input wire logic katDone,
  input wire logic katPass,
  output logic cryptoReady,
  output logic selftestError
);
  giv_st_e state_r;
  giv_st_e state_nxt;
  logic [2:0] katSel_r;
  logic [11:0] timer_r;
  wire timedOut = (timer_r == GIV_KAT_TIMEOUT_CYC);
  wire lastKat = (katSel_r == GIV_KAT_LAST);
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // RL1: starts from reset
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      GIV_ST_START: state_nxt = GIV_ST_RUN;
      GIV_ST_RUN: begin
        // RL2: any failure latches error
        if (timedOut || (katDone && !katPass)) state_nxt = GIV_ST_FAIL;
        else if (katDone && lastKat) state_nxt = GIV_ST_PASS;
        else if (katDone) state_nxt = GIV_ST_START;
      end
      GIV_ST_PASS: state_nxt = GIV_ST_PASS;
      GIV_ST_FAIL: state_nxt = GIV_ST_FAIL;
      default: state_nxt = GIV_ST_FAIL;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r <= GIV_ST_START;
      katSel_r <= 3'h0;
      timer_r <= 12'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == GIV_ST_RUN && katDone) katSel_r <= katSel_r + 3'h1;
      timer_r <= (state_r == GIV_ST_RUN) ? timer_r + 12'h1 : 12'h0;
    end
  end
  assign katStart = (state_r == GIV_ST_START);
  assign katSel = katSel_r;
  // RL2: service only after all pass
  assign cryptoReady = (state_r == GIV_ST_PASS);
  assign selftestError = (state_r == GIV_ST_FAIL);
endmodule

// [giv_iv_builder_checker.sv]
// Port assertions for the GCM vector builder
`timescale 1ns/1ps
module giv_iv_builder_checker
  import giv_pkg::*;
#(
  parameter logic [63:0] PSP_LIFE_CYC = GIV_PSP_LIFE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic katStart,
  input wire logic [2:0] katSel,
  input wire logic katDone,
  input wire logic katPass,
  input wire logic cryptoReady,
  input wire logic selftestError,
  input wire logic ctrlReq,
  input wire logic ctrlReject,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [giv_pkg::GIV_SCH_W-1:0] reqScheme,
  input wire logic [giv_pkg::GIV_SA_W-1:0] reqSaIndex,
  input wire logic [giv_pkg::GIV_VAR_W-1:0] reqSeqNum,
  input wire logic [giv_pkg::GIV_VAR_W-1:0] reqSaStart,
  input wire logic outStall,
  input wire logic saDeact,
  input wire logic [giv_pkg::GIV_SA_W-1:0] saDeactIndex,
  input wire logic [giv_pkg::GIV_VAR_W-1:0] masterTime,
  input wire logic ivValid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic taken = reqValid && reqReady;
  a_kat_autostart:
    assert property (resetn && !$past(resetn) |-> ##[0:1] (katStart && katSel == 3'h0))
    else $error("self-test not started");
  a_kat_order:
    assert property (katStart && katSel != 3'h0 |-> $past(katDone && katPass)
      && $past(katSel) == katSel - 3'h1) else $error("self-test order broken");
  a_ready_after_all:
    assert property (katDone && katPass && !katStart && katSel == GIV_KAT_LAST |=> cryptoReady)
    else $error("service not opened");
  a_fail_to_error:
    assert property (katDone && !katPass && !katStart |=> selftestError && !cryptoReady)
    else $error("failure not trapped");
  a_no_early_svc:
    assert property (!cryptoReady |-> !reqReady && !ivValid)
    else $error("service before self-test");
  a_err_silent:
    assert property (selftestError |-> !reqReady && !ivValid && ctrlReject == ctrlReq)
    else $error("error state not silent");
  a_stall_flag:
    assert property (reqValid && cryptoReady && !reqReady |-> outStall)
    else $error("stall not flagged");
  a_esp_wrap:
    assert property (taken && reqScheme == GIV_SCH_ESP && reqSeqNum == GIV_SEQ_MAX
      |=> saDeact && saDeactIndex == $past(reqSaIndex)) else $error("wrap not retired");
  a_psp_life:
    assert property (taken && reqScheme == GIV_SCH_PSP && masterTime - reqSaStart > PSP_LIFE_CYC
      |=> saDeact) else $error("old association kept");
  a_timer_step:
    assert property ($past(resetn) |-> masterTime == $past(masterTime) + 64'h1)
    else $error("timer not stepping");
  c_ready: cover property (cryptoReady && taken);
  c_error: cover property (selftestError && ctrlReq);
  c_deact: cover property (saDeact);
endmodule
bind giv_iv_builder giv_iv_builder_checker #(.PSP_LIFE_CYC(PSP_LIFE_CYC)) u_chk (
  .sys_clk, .resetn, .katStart, .katSel, .katDone, .katPass, .cryptoReady,
  .selftestError, .ctrlReq, .ctrlReject, .reqValid, .reqReady, .reqScheme,
  .reqSaIndex, .reqSeqNum, .reqSaStart, .outStall, .saDeact, .saDeactIndex,
  .masterTime, .ivValid
);

// [giv_far_end.sv]
// Far-side model: self-test engine and downstream sink
`timescale 1ns/1ps
module giv_far_end (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic katStart,
  input wire logic [2:0] katSel,
  input wire logic [3:0] failSel,
  input wire logic hold,
  output logic katDone,
  output logic katPass,
  output logic ivReady
);
  integer seed = 32'h146d08bb;
  integer lag;
  initial begin
    katDone = 1'b0;
    katPass = 1'b0;
    ivReady = 1'b0;
  end
  // Random back-pressure keeps the output FIFO partly full
  always @(negedge sys_clk) ivReady <= !hold && ($random(seed) % 3 != 0);
  // Random lag per test; failSel[3] high means all pass
  // Idle in reset: a late answer would land in run and be lost
  always @(posedge sys_clk) begin
    if (resetn === 1'b1 && katStart === 1'b1) begin
      lag = 1 + {$random(seed)} % 6;
      repeat (lag) @(negedge sys_clk);
      katPass <= failSel[3] || katSel != failSel[2:0];
      katDone <= 1'b1;
      @(negedge sys_clk);
      katDone <= 1'b0;
      katPass <= !katPass;
    end
  end
endmodule

// [tb_giv_iv_builder.sv]
// Self-checking bench for the GCM vector builder
`timescale 1ns/1ps
module tb_giv_iv_builder;
  import giv_pkg::*;
  localparam logic [63:0] LIFE = 64'h64;
  logic sys_clk, resetn, katStart, katDone, katPass, cryptoReady, selftestError, hold;
  logic ctrlReq, ctrlAccept, ctrlReject, tableAdd, reqValid, reqReady, outStall, saDeact;
  logic ivValid, ivReady;
  logic [2:0] katSel;
  logic [3:0] failSel;
  logic [1:0] reqScheme, ivScheme;
  logic [15:0] reqSaIndex, saDeactIndex, ivSaIndex;
  logic [31:0] tableSalt, reqSalt;
  logic [63:0] reqSeqNum, reqSaStart, masterTime, tmr, adds;
  logic [95:0] ivData;
  logic [GIV_DESC_W-1:0] q[$];
  integer seed = 32'h146d08bb;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  giv_iv_builder #(.PSP_LIFE_CYC(LIFE)) u_giv_iv_builder (
    .sys_clk, .resetn, .katStart, .katSel, .katDone, .katPass, .cryptoReady,
    .selftestError, .ctrlReq, .ctrlAccept, .ctrlReject, .tableSalt, .tableAdd,
    .reqValid, .reqReady, .reqScheme, .reqSaIndex, .reqSalt, .reqSeqNum, .reqSaStart,
    .outStall, .saDeact, .saDeactIndex, .masterTime, .ivValid, .ivReady, .ivScheme,
    .ivSaIndex, .ivData
  );
  giv_far_end u_giv_far_end (
    .sys_clk, .resetn, .katStart, .katSel, .failSel, .hold, .katDone, .katPass, .ivReady
  );
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    tmr <= resetn ? tmr + 64'h1 : 64'h0;
    adds <= resetn ? adds + 64'(tableAdd) : 64'h0;
    if (resetn && ivValid && ivReady) check({ivScheme, ivSaIndex, ivData}, q.pop_front());
  end
  task automatic check(input logic [GIV_DESC_W-1:0] got, input logic [GIV_DESC_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic startup(input logic [3:0] f);
    failSel = f;
    resetn = 1'b0;
    reqScheme = 2'h3;
    reqValid = 1'b1;
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    for (n = 0; n < 300 && !cryptoReady && !selftestError; n++) begin
      check(reqReady, 1'b0);
      @(negedge sys_clk);
    end
    reqValid = 1'b0;
  endtask
  task automatic addp;
    @(negedge sys_clk);
    tableAdd = 1'b1;
    @(negedge sys_clk);
    tableAdd = 1'b0;
  endtask
  task automatic send(input logic [1:0] s, input logic [63:0] v, input logic dea);
    logic [63:0] vv;
    @(negedge sys_clk);
    reqScheme = s;
    reqSeqNum = v;
    reqSaIndex = 16'($random(seed));
    reqSalt = $random(seed);
    reqSaStart = dea ? tmr - LIFE - 64'h1 : tmr;
    reqValid = 1'b1;
    for (n = 0; n < 20; n++) begin
      #1;
      if (reqReady === 1'b1) break;
      @(negedge sys_clk);
    end
    check(reqReady, 1'b1);
    check(masterTime, tmr);
    vv = s == GIV_SCH_PSP ? tmr : (s == GIV_SCH_TABLE ? adds : v);
    if (s != 2'h3 && !dea)
      q.push_back({s, reqSaIndex, s == GIV_SCH_TABLE ? tableSalt : reqSalt, vv});
    @(negedge sys_clk);
    reqValid = 1'b0;
    check(saDeact, dea);
    if (dea) check(saDeactIndex, reqSaIndex);
  endtask
  task automatic refuse(input logic [1:0] s, input logic [63:0] v);
    @(negedge sys_clk);
    reqScheme = s;
    reqSeqNum = v;
    reqValid = 1'b1;
    repeat (3) @(negedge sys_clk);
    check({reqReady, outStall || selftestError}, 2'b01);
    reqValid = 1'b0;
  endtask
  task automatic drain;
    for (n = 0; n < 300 && q.size() > 0; n++) @(negedge sys_clk);
    check(q.size(), 0);
  endtask
  initial begin
    {ctrlReq, tableAdd, reqSaIndex, reqSalt, reqSeqNum, reqSaStart} = '0;
    hold = 1'b0;
    tableSalt = $random(seed);
    startup(4'h8);
    check(cryptoReady, 1'b1);
    ctrlReq = 1'b1;
    #1 check({ctrlAccept, ctrlReject}, 2'b10);
    addp();
    send(GIV_SCH_TABLE, 64'h0, 1'b0);
    refuse(GIV_SCH_TABLE, 64'h0);
    addp();
    send(GIV_SCH_TABLE, 64'h0, 1'b0);
    send(GIV_SCH_ESP, 64'h5, 1'b0);
    refuse(GIV_SCH_ESP, 64'h5);
    send(GIV_SCH_ESP, 64'h6, 1'b0);
    send(GIV_SCH_PSP, 64'h0, 1'b0);
    send(GIV_SCH_PSP, 64'h0, 1'b1);
    send(2'h3, 64'h0, 1'b0);
    send(GIV_SCH_ESP, GIV_SEQ_MAX, 1'b1);
    drain();
    hold <= 1'b1;
    repeat (32) send(GIV_SCH_PSP, 64'h0, 1'b0);
    refuse(GIV_SCH_PSP, 64'h0);
    hold <= 1'b0;
    drain();
    startup(4'h2);
    check({selftestError, cryptoReady}, 2'b10);
    #1 check({ctrlAccept, ctrlReject}, 2'b01);
    refuse(GIV_SCH_ESP, 64'h7);
    check(ivValid, 1'b0);
    give_verdict();
  end
  // Whole run needs under 3000 cycles; ten times that is a hang
  initial begin
    #600000;
    bad_count++;
    give_verdict();
  end
endmodule
